//--- src/scd_dac_cal_sel.sv
// shared DAC calibration select: level and calibration registers of the
// four shared level DACs, copy selection from the mode bits, AXI4-Lite slave
// assumes one 25 MHz clock; bus master keeps AXI4-Lite handshakes
//
// Behaviour
// - comparator calibration uses the window copy with hiz and diff at 0, the differential copy with hiz 0, diff 1, and the PMU comparator copy with hiz at 1.
// - the force DAC uses its voltage copy when hiz and measure bit are 0, or when hiz is 1 and the force bit is 0.
// - otherwise the force copy follows the range select: top bit 1 is range A, low bits 11, 10, 01, 00 give ranges B, C, D, E.
// - the clamp/high-voltage DAC uses its clamp copy with hiz at 1 and its driver high-voltage copy with hiz at 0.
// - each level DAC is driven with a 16-bit level code whose 0 V code is 16384.
// - the three identical DACs get an 8-bit offset code and a gain code in steps of one thirty-second.
// - the force DAC gain code has one extra bit for steps of one sixty-fourth.
// - offset codes span 0 to 255, force gain 0 to 127, other gains 0 to 63.
// - offset and gain codes given to a DAC come straight from its selected calibration copy.
// - at power-on every level code is the 0 V code and every calibration copy is midscale.
// - a calibration write reaches the copy that the current mode selects, and the DAC switches copies as the mode changes.
// - the reset pin restores level and mode registers but leaves calibration copies untouched.
`timescale 1ns/1ns
`include "scd_regs.svh"

module scd_dac_cal_sel (
  // clock and resets
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 por_n,
  // axi4-lite write address and data
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // comparator high / pmu high comparator dac
  output scd_pkg::scd_level_t       comp_high_level,
  output logic [7:0]                comp_high_offset,
  output logic [5:0]                comp_high_gain,
  // comparator low / pmu low comparator dac
  output scd_pkg::scd_level_t       comp_low_level,
  output logic [7:0]                comp_low_offset,
  output logic [5:0]                comp_low_gain,
  // pmu force value dac
  output scd_pkg::scd_level_t       pmu_force_level,
  output logic [7:0]                pmu_force_offset,
  output logic [6:0]                pmu_force_gain,
  // pmu high clamp / driver super voltage dac
  output scd_pkg::scd_level_t       pmu_high_clamp_level,
  output logic [7:0]                pmu_high_clamp_offset,
  output logic [5:0]                pmu_high_clamp_gain
);
  import scd_pkg::*;

  // ==========================================================
  // state
  // ==========================================================
  logic [`SCD_MODE_W-1:0] mode_reg;
  scd_level_t             lvl_reg [0:3];
  scd_cal_t               cal_reg [0:`SCD_CAL_N-1];
  logic                   wr_take_reg;

  // ==========================================================
  // copy selection
  // ==========================================================
  // pure decode of the live mode bits, shared by write path and outputs
  function automatic scd_idx_t cal_index(scd_dac_t dac,
                                         logic [`SCD_MODE_W-1:0] m);
    logic     hiz;
    logic     volt;
    scd_idx_t sub;
    hiz  = m[`SCD_MODE_HIZ];
    volt = (!hiz && !m[`SCD_MODE_MKIND]) ||
           (hiz && !m[`SCD_MODE_FKIND]);
    sub  = `SCD_PF_RE;
    case (dac)
      SCD_DAC_CH, SCD_DAC_CL: begin
        if (hiz)
          sub = `SCD_CMP_PMU;
        else if (m[`SCD_MODE_DIFF])
          sub = `SCD_CMP_DIFF;
        else
          sub = `SCD_CMP_WIN;
        cal_index = (dac == SCD_DAC_CH) ? `SCD_BASE_CH + sub
                                        : `SCD_BASE_CL + sub;
      end
      SCD_DAC_PF: begin
        if (volt)
          sub = `SCD_PF_VOLT;
        else if (m[`SCD_MODE_RS_HI])
          sub = `SCD_PF_RA;
        else begin
          case (m[`SCD_MODE_RS_HI-1:`SCD_MODE_RS_LO])
            `SCD_RS_B: sub = `SCD_PF_RB;
            `SCD_RS_C: sub = `SCD_PF_RC;
            `SCD_RS_D: sub = `SCD_PF_RD;
            default:   sub = `SCD_PF_RE;
          endcase
        end
        cal_index = `SCD_BASE_PF + sub;
      end
      default: begin
        sub = hiz ? `SCD_CP_CLAMP : `SCD_CP_DRV;
        cal_index = `SCD_BASE_CP + sub;
      end
    endcase
  endfunction : cal_index

  // calibration offsets that select a dac, or none
  function automatic logic cal_addr_dac(logic [7:0] a, output scd_dac_t d);
    cal_addr_dac = 1'b1;
    case (a)
      `SCD_ADDR_CAL_CH: d = SCD_DAC_CH;
      `SCD_ADDR_CAL_CL: d = SCD_DAC_CL;
      `SCD_ADDR_CAL_PF: d = SCD_DAC_PF;
      `SCD_ADDR_CAL_CP: d = SCD_DAC_CP;
      default: begin
        d = SCD_DAC_CH;
        cal_addr_dac = 1'b0;
      end
    endcase
  endfunction : cal_addr_dac

  scd_idx_t sel_ch;
  scd_idx_t sel_cl;
  scd_idx_t sel_pf;
  scd_idx_t sel_cp;

  assign sel_ch = cal_index(SCD_DAC_CH, mode_reg);
  assign sel_cl = cal_index(SCD_DAC_CL, mode_reg);
  assign sel_pf = cal_index(SCD_DAC_PF, mode_reg);
  assign sel_cp = cal_index(SCD_DAC_CP, mode_reg);

  // ==========================================================
  // write channel
  // ==========================================================
  // both channels taken in one cycle; the master holds whichever it offers
  logic wr_go;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
                 !wr_take_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || !por_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      wr_take_reg   <= 1'b0;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      wr_take_reg   <= wr_go;
    end
  end

  logic      wr_do;
  logic      wr_is_cal;
  scd_dac_t  wr_dac;
  logic [15:0] wr_merged16;
  logic [15:0] wr_old16;
  logic        wr_known;

  assign wr_do     = wr_take_reg;
  // a function with an output argument needs a procedural caller
  always_comb wr_is_cal = cal_addr_dac(s_axi_awaddr, wr_dac);

  // byte lanes merged into the addressed 16-bit register
  always_comb begin
    wr_old16 = 16'h0000;
    wr_known = 1'b1;
    if (wr_is_cal)
      wr_old16 = {1'b0, cal_reg[cal_index(wr_dac, mode_reg)]};
    else begin
      case (s_axi_awaddr)
        `SCD_ADDR_MODE:   wr_old16 = {9'h000, mode_reg};
        `SCD_ADDR_LVL_CH: wr_old16 = lvl_reg[SCD_DAC_CH];
        `SCD_ADDR_LVL_CL: wr_old16 = lvl_reg[SCD_DAC_CL];
        `SCD_ADDR_LVL_PF: wr_old16 = lvl_reg[SCD_DAC_PF];
        `SCD_ADDR_LVL_CP: wr_old16 = lvl_reg[SCD_DAC_CP];
        default:          wr_known = 1'b0;
      endcase
    end
    wr_merged16[7:0]  = s_axi_wstrb[0] ? s_axi_wdata[7:0]  : wr_old16[7:0];
    wr_merged16[15:8] = s_axi_wstrb[1] ? s_axi_wdata[15:8] : wr_old16[15:8];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !por_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SCD_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? `SCD_RESP_OKAY : `SCD_RESP_SLVERR;
    end else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================================
  // mode and level registers: restored by the reset pin
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn || !por_n)
      mode_reg <= `SCD_MODE_RST;
    else if (wr_do && s_axi_awaddr == `SCD_ADDR_MODE)
      mode_reg <= wr_merged16[`SCD_MODE_W-1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !por_n) begin
      for (int i = 0; i < 4; i++)
        lvl_reg[i] <= `SCD_LVL_RST;
    end else if (wr_do) begin
      case (s_axi_awaddr)
        `SCD_ADDR_LVL_CH: lvl_reg[SCD_DAC_CH] <= wr_merged16;
        `SCD_ADDR_LVL_CL: lvl_reg[SCD_DAC_CL] <= wr_merged16;
        `SCD_ADDR_LVL_PF: lvl_reg[SCD_DAC_PF] <= wr_merged16;
        `SCD_ADDR_LVL_CP: lvl_reg[SCD_DAC_CP] <= wr_merged16;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // calibration copies: power-on only, the reset pin leaves them
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      for (int i = 0; i < `SCD_CAL_N; i++)
        cal_reg[i] <= (i >= `SCD_BASE_PF && i < `SCD_BASE_CP) ?
                      `SCD_CAL_PF_RST : `SCD_CAL_RST;
    end else if (wr_do && wr_is_cal) begin
      // unused gain bit forced to zero keeps six-bit gains in range
      cal_reg[cal_index(wr_dac, mode_reg)] <=
        (wr_dac == SCD_DAC_PF) ? wr_merged16[14:0] & `SCD_CAL_MASK7
                               : wr_merged16[14:0] & `SCD_CAL_MASK6;
    end
  end

  // ==========================================================
  // read channel
  // ==========================================================
  logic     rd_go;
  logic     rd_cal;
  scd_dac_t rd_dac;
  assign rd_go  = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  always_comb rd_cal = cal_addr_dac(s_axi_araddr, rd_dac);

  always_ff @(posedge aclk) begin
    if (!aresetn || !por_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SCD_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SCD_RESP_OKAY;
        if (rd_cal)
          s_axi_rdata <= {17'h00000, cal_reg[cal_index(rd_dac, mode_reg)]};
        else begin
          case (s_axi_araddr)
            `SCD_ADDR_MODE:   s_axi_rdata <= {25'h0000000, mode_reg};
            `SCD_ADDR_LVL_CH: s_axi_rdata <= {16'h0000, lvl_reg[SCD_DAC_CH]};
            `SCD_ADDR_LVL_CL: s_axi_rdata <= {16'h0000, lvl_reg[SCD_DAC_CL]};
            `SCD_ADDR_LVL_PF: s_axi_rdata <= {16'h0000, lvl_reg[SCD_DAC_PF]};
            `SCD_ADDR_LVL_CP: s_axi_rdata <= {16'h0000, lvl_reg[SCD_DAC_CP]};
            `SCD_ADDR_STATUS:
              s_axi_rdata <= {16'h0000, sel_cp, sel_pf, sel_cl, sel_ch};
            default: begin
              s_axi_rdata <= 32'h0000_0000;
              s_axi_rresp <= `SCD_RESP_SLVERR;
            end
          endcase
        end
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // dac codes, one register stage after the selected copy
  // ==========================================================
  always_ff @(posedge aclk) begin
    comp_high_level       <= lvl_reg[SCD_DAC_CH];
    comp_low_level        <= lvl_reg[SCD_DAC_CL];
    pmu_force_level       <= lvl_reg[SCD_DAC_PF];
    pmu_high_clamp_level  <= lvl_reg[SCD_DAC_CP];
    comp_high_offset      <= cal_reg[sel_ch][`SCD_OFS_HI:`SCD_OFS_LO];
    comp_high_gain        <= cal_reg[sel_ch][`SCD_GAIN6_HI:`SCD_GAIN_LO];
    comp_low_offset       <= cal_reg[sel_cl][`SCD_OFS_HI:`SCD_OFS_LO];
    comp_low_gain         <= cal_reg[sel_cl][`SCD_GAIN6_HI:`SCD_GAIN_LO];
    pmu_force_offset      <= cal_reg[sel_pf][`SCD_OFS_HI:`SCD_OFS_LO];
    pmu_force_gain        <= cal_reg[sel_pf][`SCD_GAIN7_HI:`SCD_GAIN_LO];
    pmu_high_clamp_offset <= cal_reg[sel_cp][`SCD_OFS_HI:`SCD_OFS_LO];
    pmu_high_clamp_gain   <= cal_reg[sel_cp][`SCD_GAIN6_HI:`SCD_GAIN_LO];
  end

endmodule : scd_dac_cal_sel

//--- src/scd_regs.svh
// register offsets, field positions and reset values of the shared DAC
// calibration select block; definitions only, no logic
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH

// byte offsets on the AXI4-Lite bus
`define SCD_ADDR_MODE      8'h00
`define SCD_ADDR_LVL_CH    8'h04
`define SCD_ADDR_LVL_CL    8'h08
`define SCD_ADDR_LVL_PF    8'h0c
`define SCD_ADDR_LVL_CP    8'h10
`define SCD_ADDR_CAL_CH    8'h14
`define SCD_ADDR_CAL_CL    8'h18
`define SCD_ADDR_CAL_PF    8'h1c
`define SCD_ADDR_CAL_CP    8'h20
`define SCD_ADDR_STATUS    8'h24

// mode register fields
`define SCD_MODE_HIZ       0
`define SCD_MODE_DIFF      1
`define SCD_MODE_FKIND     2
`define SCD_MODE_MKIND     3
`define SCD_MODE_RS_LO     4
`define SCD_MODE_RS_HI     6
`define SCD_MODE_W         7
`define SCD_MODE_RST       7'h00

// calibration word fields: offset code low, gain code above it
`define SCD_OFS_LO         0
`define SCD_OFS_HI         7
`define SCD_GAIN_LO        8
`define SCD_GAIN6_HI       13
`define SCD_GAIN7_HI       14
`define SCD_CAL_W          15
`define SCD_CAL_RST        15'h2080
`define SCD_CAL_PF_RST     15'h4080
`define SCD_CAL_MASK6      15'h3fff
`define SCD_CAL_MASK7      15'h7fff

// level code: 0 V code
`define SCD_LVL_RST        16'h4000

// calibration copy storage: base index of each shared DAC
`define SCD_CAL_N          14
`define SCD_BASE_CH        4'h0
`define SCD_BASE_CL        4'h3
`define SCD_BASE_PF        4'h6
`define SCD_BASE_CP        4'hc

// copy offsets inside one DAC
`define SCD_CMP_WIN        4'h0
`define SCD_CMP_DIFF       4'h1
`define SCD_CMP_PMU        4'h2
`define SCD_PF_VOLT        4'h0
`define SCD_PF_RA          4'h1
`define SCD_PF_RB          4'h2
`define SCD_PF_RC          4'h3
`define SCD_PF_RD          4'h4
`define SCD_PF_RE          4'h5
`define SCD_CP_DRV         4'h0
`define SCD_CP_CLAMP       4'h1

`define SCD_RS_B           2'b11
`define SCD_RS_C           2'b10
`define SCD_RS_D           2'b01

`define SCD_RESP_OKAY      2'b00
`define SCD_RESP_SLVERR    2'b10

`endif

//--- src/scd_pkg.sv
// types shared by the shared DAC calibration select block
// assumes scd_regs.svh supplies the numeric constants
package scd_pkg;
  typedef logic [15:0] scd_level_t;
  typedef logic [14:0] scd_cal_t;
  typedef logic [3:0]  scd_idx_t;
  typedef enum logic [1:0] {
    SCD_DAC_CH,
    SCD_DAC_CL,
    SCD_DAC_PF,
    SCD_DAC_CP
  } scd_dac_t;
endpackage : scd_pkg

//--- sim/scd_dac_cal_sel_monitor.sv
// checker for the shared dac calibration select block
// assumes one clock domain; aresetn and por_n synchronous, active low
`timescale 1ns/1ns

module scd_dac_cal_sel_monitor (
  // clock and resets
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                por_n,
  // bus handshakes
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rready,
  // dac codes
  input wire scd_pkg::scd_level_t comp_high_level,
  input wire scd_pkg::scd_level_t pmu_force_level,
  input wire logic [7:0]          comp_high_offset,
  input wire logic [5:0]          comp_high_gain,
  input wire logic [7:0]          pmu_force_offset,
  input wire logic [6:0]          pmu_force_gain
);
  import scd_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !por_n);

  // ==========
  // bus
  aw_w_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("write address and data ready differ");
  wr_resp_a: assert property (s_axi_awready |-> ##[1:2] s_axi_bvalid)
    else $error("no write response after handshake");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rd_resp_a: assert property (s_axi_arready |-> s_axi_rvalid ##1
    !s_axi_arready)
    else $error("read answer missing or ready too long");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");

  // ==========
  // dac codes
  lvl_rst_a: assert property ($rose(aresetn) |->
    comp_high_level == 16'h4000 && pmu_force_level == 16'h4000)
    else $error("level code not at 0 V code after reset");
  cal_por_a: assert property ($rose(por_n) |->
    {comp_high_offset, comp_high_gain} == {8'h80, 6'h20} &&
    {pmu_force_offset, pmu_force_gain} == {8'h80, 7'h40})
    else $error("calibration copy not midscale after power-on");
  // codes move only after a bus write has completed
  out_cause_a: assert property ($past(aresetn, 2) && $past(por_n, 2) &&
    $changed({comp_high_offset, comp_high_gain, pmu_force_offset,
    pmu_force_gain}) |-> $past(s_axi_bvalid))
    else $error("dac code changed without a bus write");

  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(por_n));
endmodule : scd_dac_cal_sel_monitor

bind scd_dac_cal_sel scd_dac_cal_sel_monitor mon_u (
  .aclk(aclk), .aresetn(aresetn), .por_n(por_n),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rready(s_axi_rready), .comp_high_level(comp_high_level),
  .pmu_force_level(pmu_force_level), .comp_high_offset(comp_high_offset),
  .comp_high_gain(comp_high_gain), .pmu_force_offset(pmu_force_offset),
  .pmu_force_gain(pmu_force_gain));

//--- sim/scd_host_model.sv
// host software model: axi4-lite master for the calibration block
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ns
`include "scd_regs.svh"

module scd_host_model (
  // clock
  input  wire logic        aclk,
  // write side
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // read side
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
  initial {araddr, arvalid, rready} = '0;

  // ==========
  // bus cycles; released payload is inverted, never left showing
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wready && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!(bvalid && aw_done && w_done));
    bready <= 1'b0;
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd

  // mode first, then gain at midscale offset, then offset
  task automatic cal(input logic [7:0] mode, input logic [7:0] a,
                     input logic [6:0] gain, input logic [7:0] ofs);
    logic [1:0] r;
    wr(`SCD_ADDR_MODE, {24'h0, mode}, r);
    wr(a, {17'h0, gain, 8'h80}, r);
    wr(a, {17'h0, gain, ofs}, r);
  endtask : cal
endmodule : scd_host_model

//--- sim/scd_dac_cal_sel_test.sv
// self-checking bench for the shared dac calibration select block
// assumes scd_host_model drives every bus input of the design
`timescale 1ns/1ns
`include "scd_regs.svh"

module scd_dac_cal_sel_test;
  import scd_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        por_n = 1'b0;
  logic [7:0]  awaddr, araddr, ch_ofs, cl_ofs, pf_ofs, cp_ofs;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  scd_level_t  ch_lvl, cl_lvl, pf_lvl, cp_lvl;
  logic [5:0]  ch_gain, cl_gain, cp_gain;
  logic [6:0]  pf_gain;
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;

  scd_host_model host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  scd_dac_cal_sel dut_u (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .comp_high_level(ch_lvl), .comp_high_offset(ch_ofs),
    .comp_high_gain(ch_gain), .comp_low_level(cl_lvl),
    .comp_low_offset(cl_ofs), .comp_low_gain(cl_gain),
    .pmu_force_level(pf_lvl), .pmu_force_offset(pf_ofs),
    .pmu_force_gain(pf_gain), .pmu_high_clamp_level(cp_lvl),
    .pmu_high_clamp_offset(cp_ofs), .pmu_high_clamp_gain(cp_gain));

  // ==========
  // clock, hang limit, shared tasks
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : ck

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    host_u.wr(a, d, rsp);
    ck({30'h0, rsp}, {30'h0, `SCD_RESP_OKAY});
  endtask : w

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    host_u.rd(a, rd_val, rsp);
    ck(rd_val, e);
  endtask : rchk

  // codes follow a register change one clock later
  task automatic settle;
    repeat (2) @(posedge aclk);
  endtask : settle

  // ==========
  // scenarios
  task automatic t_power;
    settle();
    ck({ch_lvl, pf_lvl}, 32'h4000_4000);
    ck({cl_lvl, cp_lvl}, 32'h4000_4000);
    ck({ch_ofs, 2'b0, ch_gain, cp_ofs, 2'b0, cp_gain}, 32'h8020_8020);
    ck({pf_ofs, 1'b0, pf_gain, cl_ofs, 2'b0, cl_gain}, 32'h8040_8020);
    rchk(`SCD_ADDR_CAL_PF, 32'h4080);
    // mode 0: window, window, force voltage, driver super copies
    rchk(`SCD_ADDR_STATUS, 32'hc630);
  endtask : t_power

  task automatic t_comp;
    logic [7:0] wm[3] = '{8'h00, 8'h02, 8'h01};
    logic [7:0] rm[3] = '{8'h7c, 8'h7e, 8'h7f};
    for (int k = 0; k < 3; k++) begin
      host_u.cal(wm[k], `SCD_ADDR_CAL_CH, 7'(k + 1), 8'(16 + k));
      host_u.cal(wm[k], `SCD_ADDR_CAL_CL, 7'(k + 4), 8'(32 + k));
    end
    for (int k = 0; k < 3; k++) begin
      w(`SCD_ADDR_MODE, {24'h0, rm[k]});
      settle();
      ck({ch_ofs, 2'b0, ch_gain, cl_ofs, 2'b0, cl_gain},
         {8'(16 + k), 8'(k + 1), 8'(32 + k), 8'(k + 4)});
    end
  endtask : t_comp

  // second encoding of each copy sets hiz, which the first encoding leaves at 0
  task automatic t_force;
    logic [7:0] wm[6] = '{8'h76, 8'h7c, 8'h3e, 8'h2e, 8'h1e, 8'h0e};
    logic [7:0] rm[6] = '{8'h79, 8'h75, 8'h3f, 8'h2f, 8'h1f, 8'h0f};
    for (int k = 0; k < 6; k++)
      host_u.cal(wm[k], `SCD_ADDR_CAL_PF, 7'(127 - k * 25), 8'(k * 51));
    for (int k = 0; k < 6; k++) begin
      w(`SCD_ADDR_MODE, {24'h0, rm[k]});
      settle();
      ck({16'h0, pf_ofs, 1'b0, pf_gain},
         {16'h0, 8'(k * 51), 1'b0, 7'(127 - k * 25)});
      rchk(`SCD_ADDR_CAL_PF, {17'h0, 7'(127 - k * 25), 8'(k * 51)});
    end
  endtask : t_force

  task automatic t_clamp;
    host_u.cal(8'h00, `SCD_ADDR_CAL_CP, 7'h3f, 8'h00);
    host_u.cal(8'h01, `SCD_ADDR_CAL_CP, 7'h00, 8'hff);
    w(`SCD_ADDR_MODE, 32'h7e);
    settle();
    ck({16'h0, cp_ofs, 2'b0, cp_gain}, 32'h003f);
    w(`SCD_ADDR_MODE, 32'h7f);
    settle();
    ck({16'h0, cp_ofs, 2'b0, cp_gain}, 32'hff00);
    w(`SCD_ADDR_CAL_CP, 32'hffff_ffff);
    rchk(`SCD_ADDR_CAL_CP, 32'h3fff);
    settle();
    ck({16'h0, cp_ofs, 2'b0, cp_gain}, 32'hff3f);
  endtask : t_clamp

  task automatic t_unmapped;
    host_u.wr(8'h28, 32'h1234, rsp);
    ck({30'h0, rsp}, {30'h0, `SCD_RESP_SLVERR});
    host_u.rd(8'h28, rd_val, rsp);
    ck({rsp, rd_val[29:0]}, {`SCD_RESP_SLVERR, 30'h0});
  endtask : t_unmapped

  task automatic t_resets;
    w(`SCD_ADDR_LVL_CH, 32'hffff);
    w(`SCD_ADDR_LVL_PF, 32'h0);
    w(`SCD_ADDR_LVL_CL, 32'h1234);
    w(`SCD_ADDR_LVL_CP, 32'hbeef);
    settle();
    ck({ch_lvl, pf_lvl}, 32'hffff_0000);
    ck({cl_lvl, cp_lvl}, 32'h1234_beef);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    ck({ch_lvl, pf_lvl}, 32'h4000_4000);
    ck({cl_lvl, cp_lvl}, 32'h4000_4000);
    rchk(`SCD_ADDR_MODE, 32'h0);
    ck({ch_ofs, 2'b0, ch_gain, cp_ofs, 2'b0, cp_gain}, 32'h1001_003f);
    por_n <= 1'b0;
    repeat (3) @(posedge aclk);
    por_n <= 1'b1;
    rchk(`SCD_ADDR_CAL_CH, 32'h2080);
    host_u.cal(8'h00, `SCD_ADDR_CAL_CH, 7'h01, 8'h10);
    settle();
    ck({16'h0, ch_ofs, 2'b0, ch_gain}, 32'h1001);
  endtask : t_resets

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    t_power();
    t_comp();
    t_force();
    t_clamp();
    t_unmapped();
    t_resets();
    tally_and_finish();
  end
endmodule : scd_dac_cal_sel_test
